// ===== inc/apsp_consts.vh
`ifndef APSP_CONSTS_VH
`define APSP_CONSTS_VH
// Result and selection widths
`define APSP_RESULT_W 14
`define APSP_CHAN_N 4
// Channel select register reset value (all channels included)
`define APSP_CHSEL_RESET 4'hf
// Field positions on the data lines
`define APSP_UPPER_LSB 6
`define APSP_MIDDLE_LSB 4
// Timing: conversion per channel in ns, done pulse in ns
`define APSP_CONV_NS 2400
`define APSP_DONE_NS 20
`define APSP_CLK_NS 5
`define APSP_CONV_CYC ((`APSP_CONV_NS) / (`APSP_CLK_NS))
`define APSP_DONE_CYC (((`APSP_DONE_NS) + (`APSP_CLK_NS) - 1) / (`APSP_CLK_NS))
// Coding select values
`define APSP_CODE_TWOS 1'b0
`define APSP_CODE_BINARY 1'b1
`endif

// ===== design/apsp_sync2.v
`timescale 1ns/1ps
module apsp_sync2
#(
  parameter WIDTH = 1
)
(
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;

always @(posedge clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    stage1 <= {WIDTH{1'b0}};
    sync_out <= {WIDTH{1'b0}};
  end
  else
  begin
    stage1 <= async_in;
    sync_out <= stage1;
  end
end

endmodule // apsp_sync2

// ===== design/apsp_port.v
`timescale 1ns/1ps
`include "apsp_consts.vh"
// What this block does
// - Each result goes out on 14 parallel lines with bit 13 as the most significant.
// - Results are twos complement for bipolar variants and straight binary for the unipolar one.
// - The result lines are three-state and released whenever no read is in progress.
// - The four low lines are two-way: driven during reads, written by the host with chip select and write strobe.
// - Line 0 of the select value controls channel 1, up to line 3 controlling channel 4.
// - A short low pulse marks the end of every single channel conversion in a sequence.
// - A select bit at one includes its channel and at zero excludes it.
// - The selection is latched on the rising edge of sample start and only affects the next sequence.
// - With source select high the register sets the sequence, with it low the include pins do.
module apsp_port
#(
  parameter CONV_CYC = `APSP_CONV_CYC,
  parameter DONE_CYC = `APSP_DONE_CYC
)
(
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Host bus pins
  input wire chip_select_n_in,
  input wire read_n_in,
  input wire write_n_in,
  input wire [3:0] low_nibble_lines_in,
  output reg [3:0] low_nibble_lines_out,
  output wire low_nibble_lines_oe_out,
  output reg [1:0] middle_result_lines_out,
  output reg [7:0] upper_result_lines_out,
  output wire result_lines_oe_out,
  // Sequence control pins
  input wire sample_start_n_in,
  input wire source_select_in,
  input wire [3:0] channel_include_pins_in,
  input wire unipolar_coding_in,
  // Converter core side
  input wire [`APSP_RESULT_W-1:0] core_result_in,
  output reg [1:0] core_channel_out,
  output wire core_busy_out,
  output reg conversion_done_n_out
);

////////////////////////////////////////////////////////////////////////
localparam S_IDLE = 3'b001;
localparam S_CONV = 3'b010;
localparam S_NEXT = 3'b100;

wire cs_act_s;
wire rd_act_s;
wire wr_act_s;
wire start_act_s;
wire cs_n_s;
wire rd_n_s;
wire wr_n_s;
wire start_n_s;
wire src_s;
wire uni_s;
wire [3:0] pins_s;
wire [3:0] nib_s;
wire [3:0] selected_set;

// Strobes pass inverted so the flops reset to their idle level,
// else reset release would look like a start or write edge
apsp_sync2 #(.WIDTH(4)) u_sync_strobe
(
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .async_in({~chip_select_n_in, ~read_n_in, ~write_n_in, ~sample_start_n_in}),
  .sync_out({cs_act_s, rd_act_s, wr_act_s, start_act_s})
);

// Level controls; source and pins looked at only on a start edge, coding at each conversion end
apsp_sync2 #(.WIDTH(6)) u_sync_ctrl
(
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .async_in({source_select_in, unipolar_coding_in, channel_include_pins_in}),
  .sync_out({src_s, uni_s, pins_s})
);

// Host data, held still by the host around the strobe edge
apsp_sync2 #(.WIDTH(4)) u_sync_data
(
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .async_in(low_nibble_lines_in),
  .sync_out(nib_s)
);

assign cs_n_s = ~cs_act_s;
assign rd_n_s = ~rd_act_s;
assign wr_n_s = ~wr_act_s;
assign start_n_s = ~start_act_s;

////////////////////////////////////////////////////////////////////////
reg [3:0] channel_sequence_select;
reg [3:0] pending;
reg wr_n_d;
reg start_n_d;
reg [2:0] state;
reg [11:0] conv_cnt;
reg [7:0] done_cnt;
reg [`APSP_RESULT_W-1:0] result_q;

wire reading = ~cs_n_s & ~rd_n_s;
wire wr_rise = wr_n_s & ~wr_n_d;
wire start_rise = start_n_s & ~start_n_d;
// Source looked at only on the start edge, so later changes wait
assign selected_set = src_s ? channel_sequence_select : pins_s;

// Lowest pending channel first
function [1:0] apsp_first;
  input [3:0] set;
  begin
    apsp_first = set[0] ? 2'h0 : set[1] ? 2'h1 : set[2] ? 2'h2 : 2'h3;
  end
endfunction

assign result_lines_oe_out = reading;
assign low_nibble_lines_oe_out = reading;
assign core_busy_out = (state != S_IDLE);

always @(posedge clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    channel_sequence_select <= `APSP_CHSEL_RESET;
    wr_n_d <= 1'b1;
    start_n_d <= 1'b1;
  end
  else
  begin
    wr_n_d <= wr_n_s;
    start_n_d <= start_n_s;
    // Data already two flops old, so it matches the strobe edge
    if (wr_rise && !cs_n_s)
      channel_sequence_select <= nib_s;
  end
end

////////////////////////////////////////////////////////////////////////
always @(posedge clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    state <= S_IDLE;
    pending <= 4'h0;
    conv_cnt <= 12'h000;
    done_cnt <= 8'h00;
    core_channel_out <= 2'h0;
    conversion_done_n_out <= 1'b1;
    result_q <= {`APSP_RESULT_W{1'b0}};
  end
  else
  begin
    // A pulse set in the case below overrides this release
    if (done_cnt != 8'h00)
      done_cnt <= done_cnt - 8'h01;
    else
      conversion_done_n_out <= 1'b1;
    case (state)
      S_IDLE:
      begin
        // Starts during a sequence are ignored
        if (start_rise)
        begin
          pending <= selected_set;
          state <= S_NEXT;
        end
      end
      S_NEXT:
      begin
        // Empty selection ends at once with no pulse
        if (pending == 4'h0)
          state <= S_IDLE;
        else
        begin
          core_channel_out <= apsp_first(pending);
          conv_cnt <= CONV_CYC[11:0] - 12'h001;
          state <= S_CONV;
        end
      end
      S_CONV:
      begin
        if (conv_cnt != 12'h000)
          conv_cnt <= conv_cnt - 12'h001;
        else
        begin
          // Unipolar part shows straight binary, else flip the core offset code
          result_q <= (uni_s == `APSP_CODE_BINARY) ? core_result_in
            : {~core_result_in[`APSP_RESULT_W-1], core_result_in[`APSP_RESULT_W-2:0]};
          pending[core_channel_out] <= 1'b0;
          conversion_done_n_out <= 1'b0;
          done_cnt <= DONE_CYC[7:0] - 8'h01;
          state <= S_NEXT;
        end
      end
      default:
        state <= S_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// Register outputs so the lines change only on clock edges
always @(posedge clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    upper_result_lines_out <= 8'h00;
    middle_result_lines_out <= 2'h0;
    low_nibble_lines_out <= 4'h0;
  end
  else
  begin
    upper_result_lines_out <= result_q[13:`APSP_UPPER_LSB];
    middle_result_lines_out <= result_q[`APSP_UPPER_LSB-1:`APSP_MIDDLE_LSB];
    low_nibble_lines_out <= result_q[`APSP_MIDDLE_LSB-1:0];
  end
end

endmodule // apsp_port

// ===== verif/apsp_core_model.sv
`timescale 1ns/1ps
module apsp_core_model (
  // Core side
  input wire [1:0] channel_in,
  output wire [13:0] result_out
);
  // Channel number in the top bits makes conversion order visible
  assign result_out = {channel_in, 12'h5a3};
endmodule // apsp_core_model

// ===== verif/apsp_port_monitor.sv
`timescale 1ns/1ps
module apsp_port_monitor (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Watched pins
  input wire chip_select_n_in,
  input wire read_n_in,
  input wire sample_start_n_in,
  input wire low_nibble_lines_oe_out,
  input wire result_lines_oe_out,
  input wire [1:0] core_channel_out,
  input wire core_busy_out,
  input wire conversion_done_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_pulse;
    !conversion_done_n_out [*4] ##1 conversion_done_n_out;
  endsequence
  a_oe_pair: assert property (low_nibble_lines_oe_out == result_lines_oe_out) else $error("oe split");
  a_idle_release: assert property (read_n_in [*5] |-> !result_lines_oe_out) else $error("bus held");
  a_read_drive: assert property ((!chip_select_n_in && !read_n_in) [*5] |-> result_lines_oe_out)
    else $error("bus idle");
  a_cs_release: assert property (chip_select_n_in [*5] |-> !low_nibble_lines_oe_out) else $error("low held");
  a_done_width: assert property ($fell(conversion_done_n_out) |-> s_pulse) else $error("done width");
  a_done_in_seq: assert property ($fell(conversion_done_n_out) |-> $past(core_busy_out)) else $error("stray done");
  a_done_gap: assert property ($fell(conversion_done_n_out) |=> !$fell(conversion_done_n_out) [*7])
    else $error("done gap");
  a_chan_order: assert property (core_busy_out && $past(core_busy_out, 3) && $changed(core_channel_out)
    |-> core_channel_out > $past(core_channel_out)) else $error("order");
  a_start_edge: assert property ($rose(core_busy_out) |-> $past(sample_start_n_in, 2)) else $error("start");
endmodule // apsp_port_monitor
bind apsp_port apsp_port_monitor i_apsp_port_monitor (.*);

// ===== verif/tb.sv
`timescale 1ns/1ps
`define CK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb;
  logic clk_in = 1'h0, rst_n_in = 1'h0, cs_n = 1'h1, rd_n = 1'h1, wr_n = 1'h1, st_n = 1'h1, src = 1'h0, uni = 1'h0;
  logic [3:0] hd = 4'h0, pins = 4'h0;
  logic [14:0] r;
  // Rows: source, coding, register, pins, pulse count, last channel
  logic [14:0] rows [6] = '{15'h43e4, 15'h740b, 15'h0107, 15'h3eca, 15'h41e0, 15'h7e13};
  wire oe_lo, oe_hi, done_n, busy;
  wire [1:0] mid, ch;
  wire [3:0] lo;
  wire [7:0] up;
  wire [13:0] core;
  wire [3:0] lo_in = oe_lo ? lo : hd;
  int errors = 0, n_checks = 0, cyc = 0, cnt = 0;
  apsp_port #(.CONV_CYC(8), .DONE_CYC(4)) i_apsp_port (.clk_in, .rst_n_in, .chip_select_n_in(cs_n), .read_n_in(rd_n),
    .write_n_in(wr_n), .low_nibble_lines_in(lo_in), .low_nibble_lines_out(lo), .low_nibble_lines_oe_out(oe_lo),
    .middle_result_lines_out(mid), .upper_result_lines_out(up), .result_lines_oe_out(oe_hi), .sample_start_n_in(st_n),
    .source_select_in(src), .channel_include_pins_in(pins), .unipolar_coding_in(uni), .core_result_in(core),
    .core_channel_out(ch), .core_busy_out(busy), .conversion_done_n_out(done_n));
  apsp_core_model i_apsp_core_model (.channel_in(ch), .result_out(core));
  always #2.5 clk_in = ~clk_in;
  always @(negedge done_n) cnt++;
  always @(posedge clk_in)
  begin
    if (++cyc == 4000)
    begin
      errors++;
      final_report();
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Strobe and data held well past the pin synchronisers
  task automatic wr_sel(logic [3:0] v);
    cs_n <= 1'h0;
    hd <= v;
    wr_n <= 1'h0;
    tick(3);
    wr_n <= 1'h1;
    tick(5);
    cs_n <= 1'h1;
    tick(1);
  endtask
  task automatic run(int w);
    cnt = 0;
    st_n <= 1'h0;
    tick(3);
    st_n <= 1'h1;
    tick(w);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    tick(16);
    rst_n_in <= 1'h1;
    tick(3);
    foreach (rows[i])
    begin
      r = rows[i];
      wr_sel(r[12:9]);
      src <= r[14];
      uni <= r[13];
      pins <= r[8:5];
      run(80);
      `CK(cnt[2:0], r[4:2])
      if (r[4:2] != 3'h0)
      begin
        cs_n <= 1'h0;
        rd_n <= 1'h0;
        tick(6);
        `CK({up, mid, lo}, {r[1:0], 12'h5a3} ^ {!r[13], 13'h0})
        `CK(oe_hi, 1'h1)
        `CK(oe_lo, 1'h1)
        cs_n <= 1'h1;
        rd_n <= 1'h1;
        tick(6);
        `CK(oe_hi, 1'h0)
      end
      $display("row %0d done", i);
    end
    wr_sel(4'hf);
    run(3);
    wr_sel(4'h1);
    tick(60);
    `CK(cnt[2:0], 3'h4)
    run(80);
    `CK(cnt[2:0], 3'h1)
    $display("latch test done");
    run(8);
    rst_n_in <= 1'h0;
    tick(2);
    `CK(done_n, 1'h1)
    `CK(busy, 1'h0)
    rst_n_in <= 1'h1;
    tick(3);
    run(80);
    `CK(cnt[2:0], 3'h4)
    $display("reset test done");
    final_report();
  end
endmodule // tb
